// ---- include/blfte_pkg.sv ----
// blfte_pkg: constants and carrier types of the encoder.
// assumes one 100 MHz clock; every file imports the whole package.
// ----------------------------------------------------------------------
// How it works
// - type byte: protocol in upper nibble (0,2,4,14), frame kind in lower nibble.
// - external trigger event emits a record typed 225 on any protocol.
// - starting the interface emits a record typed 226 on any protocol.
// - a CAN bus error emits a record typed 2.
// - a FlexRay frame with payload is typed 32, all elements filled.
// - a received FlexRay null frame is typed 33.
// - null records only for static segment slots, never dynamic segment.
// - null records only when enabled, and only to stream-mode consumers.
// - null record has zero payload length, preamble and echo cleared.
// - null record fields come from the frame, stamped with reception time.
// - FlexRay symbol typed 34, payload byte zero: 0 MTS, 1 wakeup.
// - symbol payload length at least one; bytes after first reserved.
// - symbol record stamped with symbol window time.
// - symbol cycle count and channel bits coded as for data records.
// - symbol record fields other than those above are zero.
// - LIN frame with payload is typed 64, the only LIN data kind.
// - a LIN bus error emits a record typed 65.
// - flag bit 7 set for own transmitted frames, clear for received.
// - FlexRay records carry cycle count 0 to 63 in info byte.
// ----------------------------------------------------------------------
package blfte_pkg;

  // ----------------------------------------------------------------------
  // clock and timestamp tick
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // interface protocol selection and type nibbles
  // ----------------------------------------------------------------------
  localparam logic [1:0] PROTO_CAN = 2'h0;
  localparam logic [1:0] PROTO_FLEXRAY = 2'h1;
  localparam logic [1:0] PROTO_LIN = 2'h2;
  localparam logic [3:0] NIB_CAN = 4'h0;
  localparam logic [3:0] NIB_FLEXRAY = 4'h2;
  localparam logic [3:0] NIB_LIN = 4'h4;
  localparam logic [3:0] NIB_SPECIAL = 4'he;
  localparam logic [3:0] SUB_CAN_DATA = 4'h0;
  localparam logic [3:0] SUB_CAN_REMOTE = 4'h1;
  localparam logic [3:0] SUB_CAN_BUS_ERROR = 4'h2;
  localparam logic [3:0] SUB_FR_DATA = 4'h0;
  localparam logic [3:0] SUB_FR_NULL = 4'h1;
  localparam logic [3:0] SUB_FR_SYMBOL = 4'h2;
  localparam logic [3:0] SUB_LIN_DATA = 4'h0;
  localparam logic [3:0] SUB_LIN_BUS_ERROR = 4'h1;
  localparam logic [3:0] SUB_LOG_TRIGGER = 4'h1;
  localparam logic [3:0] SUB_START_TRIGGER = 4'h2;

  // ----------------------------------------------------------------------
  // flag bit positions
  // ----------------------------------------------------------------------
  localparam int FLAG_STARTUP = 0;
  localparam int FLAG_EVENT_TRIG = 0;
  localparam int FLAG_SYNC = 1;
  localparam int FLAG_PREAMBLE = 2;
  localparam int FLAG_CHAN_A = 4;
  localparam int FLAG_CHAN_B = 5;
  localparam int FLAG_ECHO = 7;

  // ----------------------------------------------------------------------
  // register map (byte offsets) and control fields
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RECORD_COUNT = 4'h8;
  localparam logic [3:0] REG_DROP_COUNT = 4'hc;
  localparam int CTRL_PROTO_LSB = 0;
  localparam int CTRL_NULL_EN = 2;
  localparam int CTRL_STREAM_MODE = 3;
  localparam int CTRL_START = 4;
  localparam int CTRL_STOP = 5;
  localparam logic [3:0] SYMBOL_MIN_LEN = 4'h1;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {KIND_DATA, KIND_REMOTE, KIND_NULL, KIND_SYMBOL} blfte_kind_type;
  typedef enum logic [2:0] {EV_NONE, EV_FRAME, EV_BUS_ERROR, EV_LOG_TRIGGER,
                            EV_START_TRIGGER} blfte_event_type;

  typedef struct packed {
    blfte_kind_type kind;
    logic echo;
    logic startup;
    logic sync;
    logic preamble;
    logic chan_a;
    logic chan_b;
    logic dynamic_segment;
    logic event_triggered;
    logic symbol_wakeup;
    logic [5:0] cycle_count;
    logic [7:0] et_frame_id;
    logic [31:0] identifier;
    logic [3:0] payload_length;
    logic [63:0] payload;
  } blfte_rx_frame_type;

  typedef struct packed {
    logic [63:0] timestamp;
    logic [31:0] identifier;
    logic [7:0] frame_type;
    logic [7:0] flags;
    logic [7:0] info;
    logic [7:0] payload_length;
    logic [63:0] payload;
  } blfte_record_type;

endpackage

// ---- verilog/blfte_timebase.sv ----
// blfte_timebase: free running microsecond timestamp for record stamping.
// assumes the package tick constant matches the clock rate.
module blfte_timebase
  import blfte_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // timestamp
  output logic [63:0] time_out
);

  typedef struct packed {
    logic [15:0] div;
    logic [63:0] now;
  } blfte_tb_state_type;

  blfte_tb_state_type s_r;
  blfte_tb_state_type s_nxt;

  // ----------------------------------------------------------------------
  // divider enable and counter
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (s_r.div == 16'(TICK_COUNT - 1)) begin
      s_nxt.div = 16'h0;
      s_nxt.now = s_r.now + 64'h1;
    end else begin
      s_nxt.div = s_r.div + 16'h1;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign time_out = s_r.now;

endmodule

// ---- verilog/blfte_type_coder.sv ----
// blfte_type_coder: maps protocol, event and frame kind to a type byte.
// assumes its caller discards any event flagged as not legal.
module blfte_type_coder
  import blfte_pkg::*;
(
  // selection
  input wire logic [1:0] proto_in,
  input wire blfte_event_type event_in,
  input wire blfte_kind_type kind_in,
  // result
  output logic [7:0] type_out,
  output logic legal_out
);

  function automatic logic [7:0] make_type(input logic [3:0] nib, input logic [3:0] sub);
    make_type = {nib, sub};
  endfunction

  // ----------------------------------------------------------------------
  // code selection
  // ----------------------------------------------------------------------
  always_comb begin
    type_out = 8'h00;
    legal_out = 1'b0;
    case (event_in)
      EV_START_TRIGGER: begin
        type_out = make_type(NIB_SPECIAL, SUB_START_TRIGGER);
        legal_out = 1'b1;
      end
      EV_LOG_TRIGGER: begin
        type_out = make_type(NIB_SPECIAL, SUB_LOG_TRIGGER);
        legal_out = 1'b1;
      end
      EV_BUS_ERROR: begin
        if (proto_in == PROTO_CAN) begin
          type_out = make_type(NIB_CAN, SUB_CAN_BUS_ERROR);
          legal_out = 1'b1;
        end else if (proto_in == PROTO_LIN) begin
          type_out = make_type(NIB_LIN, SUB_LIN_BUS_ERROR);
          legal_out = 1'b1;
        end
      end
      EV_FRAME: begin
        // anything not listed for the protocol stays illegal
        if (proto_in == PROTO_CAN && kind_in == KIND_DATA) begin
          type_out = make_type(NIB_CAN, SUB_CAN_DATA);
          legal_out = 1'b1;
        end else if (proto_in == PROTO_CAN && kind_in == KIND_REMOTE) begin
          type_out = make_type(NIB_CAN, SUB_CAN_REMOTE);
          legal_out = 1'b1;
        end else if (proto_in == PROTO_FLEXRAY && kind_in == KIND_DATA) begin
          type_out = make_type(NIB_FLEXRAY, SUB_FR_DATA);
          legal_out = 1'b1;
        end else if (proto_in == PROTO_FLEXRAY && kind_in == KIND_NULL) begin
          type_out = make_type(NIB_FLEXRAY, SUB_FR_NULL);
          legal_out = 1'b1;
        end else if (proto_in == PROTO_FLEXRAY && kind_in == KIND_SYMBOL) begin
          type_out = make_type(NIB_FLEXRAY, SUB_FR_SYMBOL);
          legal_out = 1'b1;
        end else if (proto_in == PROTO_LIN && kind_in == KIND_DATA) begin
          type_out = make_type(NIB_LIN, SUB_LIN_DATA);
          legal_out = 1'b1;
        end
      end
      default: begin
        legal_out = 1'b0;
      end
    endcase
  end

endmodule

// ---- verilog/blfte_encoder.sv ----
// blfte_encoder: builds logged frame records from protocol events.
// assumes a controller presenting decoded frames and an Avalon-MM master.
module blfte_encoder
  import blfte_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // avalon-mm register slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // protocol controller frames
  input wire logic frame_valid_in,
  input wire blfte_rx_frame_type frame_in,
  output logic frame_ready_out,
  // bus error and trigger events
  input wire logic bus_error_in,
  input wire logic external_trigger_line_zero_in,
  // record stream to host
  output blfte_record_type rec_out,
  output logic rec_valid_out,
  input wire logic rec_ready_in,
  // interface state
  output logic started_out
);

  typedef struct packed {
    logic [1:0] proto;
    logic null_en;
    logic stream_mode;
    logic started;
    logic trig_prev;
    logic pend_start;
    logic pend_trig;
    logic pend_berr;
    logic out_valid;
    blfte_record_type rec;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] rec_count;
    logic [31:0] drop_count;
  } blfte_state_type;

  blfte_state_type s_r;
  blfte_state_type s_nxt;

  logic [63:0] now;
  blfte_event_type ev;
  logic [7:0] type_code;
  logic type_legal;
  logic req;
  logic wr_take;
  logic out_take;
  logic slot_free;
  logic any_pend;
  logic trig_rise;
  logic null_blocked;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] fr_flags(input blfte_rx_frame_type f);
    logic [7:0] fl;
    fl = 8'h00;
    fl[FLAG_STARTUP] = f.startup;
    fl[FLAG_SYNC] = f.sync;
    fl[FLAG_PREAMBLE] = f.preamble;
    fl[FLAG_CHAN_A] = f.chan_a;
    fl[FLAG_CHAN_B] = f.chan_b;
    fl[FLAG_ECHO] = f.echo;
    return fl;
  endfunction

  function automatic logic [7:0] echo_flag(input logic echo);
    logic [7:0] fl;
    fl = 8'h00;
    fl[FLAG_ECHO] = echo;
    return fl;
  endfunction

  function automatic logic [31:0] read_word(input blfte_state_type s, input logic [3:0] a);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      REG_CTRL: begin
        w[CTRL_PROTO_LSB +: 2] = s.proto;
        w[CTRL_NULL_EN] = s.null_en;
        w[CTRL_STREAM_MODE] = s.stream_mode;
      end
      REG_STATUS: begin
        w[4:0] = {s.pend_berr, s.pend_trig, s.pend_start, s.out_valid, s.started};
      end
      REG_RECORD_COUNT: begin
        w = s.rec_count;
      end
      REG_DROP_COUNT: begin
        w = s.drop_count;
      end
      default: begin
        w = 32'h0;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------
  blfte_timebase u_timebase (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .time_out(now)
  );

  blfte_type_coder u_type_coder (
    .proto_in(s_r.proto),
    .event_in(ev),
    .kind_in(frame_in.kind),
    .type_out(type_code),
    .legal_out(type_legal)
  );

  // ----------------------------------------------------------------------
  // event selection
  // ----------------------------------------------------------------------
  assign req = avs_read_in | avs_write_in;
  assign wr_take = avs_write_in & s_r.ack;
  assign out_take = s_r.out_valid & rec_ready_in;
  assign slot_free = ~s_r.out_valid | out_take;
  assign any_pend = s_r.pend_start | s_r.pend_trig | s_r.pend_berr;
  assign trig_rise = external_trigger_line_zero_in & ~s_r.trig_prev;
  // null frames are swallowed unless logging is on, a stream consumer exists
  // and the slot lies in the static segment
  assign null_blocked = (frame_in.kind == KIND_NULL) &
                        (~s_r.null_en | ~s_r.stream_mode | frame_in.dynamic_segment);

  always_comb begin
    ev = EV_NONE;
    if (s_r.pend_start) begin
      ev = EV_START_TRIGGER;
    end else if (s_r.pend_trig) begin
      ev = EV_LOG_TRIGGER;
    end else if (s_r.pend_berr) begin
      ev = EV_BUS_ERROR;
    end else if (frame_valid_in) begin
      ev = EV_FRAME;
    end
  end

  // frames wait behind special events and a full output slot
  assign frame_ready_out = slot_free & ~any_pend;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    blfte_record_type r;
    logic clr_start;
    logic clr_trig;
    logic clr_berr;
    logic emit;
    r = '0;
    clr_start = 1'b0;
    clr_trig = 1'b0;
    clr_berr = 1'b0;
    emit = 1'b0;
    s_nxt = s_r;

    // register bus: one wait cycle, then the answer
    s_nxt.ack = req & ~s_r.ack;
    if (avs_read_in & ~s_r.ack) begin
      s_nxt.rdata = read_word(s_r, avs_address_in);
    end
    if (wr_take && avs_address_in == REG_CTRL && avs_byteenable_in[0]) begin
      s_nxt.null_en = avs_writedata_in[CTRL_NULL_EN];
      s_nxt.stream_mode = avs_writedata_in[CTRL_STREAM_MODE];
      // protocol is frozen while the interface runs
      if (!s_r.started) begin
        s_nxt.proto = avs_writedata_in[CTRL_PROTO_LSB +: 2];
      end
    end

    // output slot
    if (out_take) begin
      s_nxt.out_valid = 1'b0;
    end

    // record assembly
    r.timestamp = now;
    r.frame_type = type_code;
    case (ev)
      EV_START_TRIGGER: begin
        clr_start = 1'b1;
      end
      EV_LOG_TRIGGER: begin
        clr_trig = 1'b1;
      end
      EV_BUS_ERROR: begin
        clr_berr = 1'b1;
      end
      EV_FRAME: begin
        case (frame_in.kind)
          KIND_NULL: begin
            r.identifier = frame_in.identifier;
            r.flags = fr_flags(frame_in);
            r.flags[FLAG_PREAMBLE] = 1'b0;
            r.flags[FLAG_ECHO] = 1'b0;
            r.info = {2'h0, frame_in.cycle_count};
            r.payload_length = 8'h00;
            r.payload = 64'h0;
          end
          KIND_SYMBOL: begin
            // only symbol kind, time, cycle, channels, wakeup byte and payload length survive
            r.flags[FLAG_CHAN_A] = frame_in.chan_a;
            r.flags[FLAG_CHAN_B] = frame_in.chan_b;
            r.info = {2'h0, frame_in.cycle_count};
            r.payload[63:56] = {7'h0, frame_in.symbol_wakeup};
            if (frame_in.payload_length < SYMBOL_MIN_LEN) begin
              r.payload_length = {4'h0, SYMBOL_MIN_LEN};
            end else begin
              r.payload_length = {4'h0, frame_in.payload_length};
            end
          end
          default: begin
            r.identifier = frame_in.identifier;
            r.payload_length = {4'h0, frame_in.payload_length};
            r.payload = frame_in.payload;
            if (s_r.proto == PROTO_FLEXRAY) begin
              r.flags = fr_flags(frame_in);
              r.info = {2'h0, frame_in.cycle_count};
            end else if (s_r.proto == PROTO_LIN) begin
              r.flags = echo_flag(frame_in.echo);
              r.flags[FLAG_EVENT_TRIG] = frame_in.event_triggered;
              r.info = frame_in.event_triggered ? frame_in.et_frame_id : 8'h00;
            end else begin
              r.flags = echo_flag(frame_in.echo);
            end
          end
        endcase
      end
      default: begin
        r = '0;
      end
    endcase

    if (slot_free && ev != EV_NONE) begin
      if (ev == EV_FRAME && null_blocked) begin
        emit = 1'b0;
      end else begin
        emit = type_legal;
      end
      if (emit) begin
        s_nxt.rec = r;
        s_nxt.out_valid = 1'b1;
        s_nxt.rec_count = s_r.rec_count + 32'h1;
      end else if (!(ev == EV_FRAME && null_blocked)) begin
        s_nxt.drop_count = s_r.drop_count + 32'h1;
      end
    end

    // pending special events; a new arrival wins over the clear
    s_nxt.trig_prev = external_trigger_line_zero_in;
    s_nxt.pend_start = s_r.pend_start & ~(clr_start & slot_free);
    s_nxt.pend_trig = s_r.pend_trig & ~(clr_trig & slot_free);
    s_nxt.pend_berr = s_r.pend_berr & ~(clr_berr & slot_free);
    if (trig_rise && s_r.started) begin
      s_nxt.pend_trig = 1'b1;
    end
    if (bus_error_in && s_r.started) begin
      s_nxt.pend_berr = 1'b1;
    end
    if (wr_take && avs_address_in == REG_CTRL && avs_byteenable_in[0]) begin
      if (avs_writedata_in[CTRL_START] && !s_r.started) begin
        s_nxt.started = 1'b1;
        s_nxt.pend_start = 1'b1;
      end else if (avs_writedata_in[CTRL_STOP]) begin
        s_nxt.started = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign avs_waitrequest_out = req & ~s_r.ack;
  assign avs_readdata_out = s_r.rdata;
  assign rec_out = s_r.rec;
  assign rec_valid_out = s_r.out_valid;
  assign started_out = s_r.started;

endmodule

// ---- verification/blfte_encoder_assertions.sv ----
// blfte_encoder_assertions: port-level checks on the record encoder.
// assumes a bind onto blfte_encoder; one clock.
module blfte_encoder_assertions
  import blfte_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // frames and triggers
  input wire logic frame_valid_in,
  input wire blfte_rx_frame_type frame_in,
  input wire logic frame_ready_out,
  input wire logic external_trigger_line_zero_in,
  // record stream and state
  input wire blfte_record_type rec_out,
  input wire logic rec_valid_out,
  input wire logic rec_ready_in,
  input wire logic started_out
);
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire take = frame_valid_in && frame_ready_out;

  type_legal_a: assert property (rec_valid_out |->
    rec_out.frame_type inside {8'h00, 8'h01, 8'h02, 8'h20, 8'h21, 8'h22, 8'h40, 8'h41,
    8'he1, 8'he2}) else $error("bad type");
  null_fields_a: assert property (take && frame_in.kind == KIND_NULL ##1 rec_valid_out |->
    rec_out.frame_type == 8'h21 && rec_out.payload_length == 8'h00 &&
    !rec_out.flags[FLAG_PREAMBLE] && !rec_out.flags[FLAG_ECHO]) else $error("bad null record");
  symbol_fields_a: assert property (take && frame_in.kind == KIND_SYMBOL ##1 rec_valid_out |->
    rec_out.frame_type == 8'h22 && rec_out.payload[63:56] == {7'h0, $past(frame_in.symbol_wakeup)}
    && rec_out.payload[55:0] == 56'h0 && rec_out.payload_length >= 8'h01 &&
    rec_out.identifier == 32'h0 && (rec_out.flags & 8'hcf) == 8'h00 &&
    rec_out.flags[FLAG_CHAN_A] == $past(frame_in.chan_a)) else $error("bad symbol record");
  echo_flag_a: assert property (take && frame_in.kind == KIND_DATA ##1 rec_valid_out |->
    rec_out.flags[FLAG_ECHO] == $past(frame_in.echo)) else $error("echo flag wrong");
  fr_cycle_a: assert property (take && frame_in.kind == KIND_DATA ##1
    (rec_valid_out && rec_out.frame_type == 8'h20) |-> rec_out.info == {2'h0,
    $past(frame_in.cycle_count)}) else $error("bad info");
  null_dynamic_a: assert property (take && frame_in.kind == KIND_NULL &&
    frame_in.dynamic_segment |=> !rec_valid_out) else $error("dynamic null logged");
  special_zero_a: assert property (rec_valid_out &&
    rec_out.frame_type inside {8'h02, 8'h41, 8'he1, 8'he2} |-> rec_out.identifier == 32'h0
    && rec_out.flags == 8'h00 && rec_out.payload == 64'h0) else $error("special not clean");
  trig_record_a: assert property (started_out && $rose(external_trigger_line_zero_in) &&
    rec_ready_in |-> ##[1:4] (rec_valid_out && rec_out.frame_type == 8'he1))
    else $error("no trigger record");
  start_record_a: assert property ($rose(started_out) && rec_ready_in |->
    ##[0:3] (rec_valid_out && rec_out.frame_type == 8'he2)) else $error("no start record");
  stall_hold_a: assert property (rec_valid_out && !rec_ready_in |=>
    rec_valid_out && $stable(rec_out)) else $error("record moved in stall");
endmodule

// ---- verification/blfte_host_model.sv ----
// blfte_host_model: record stream consumer standing in for host software.
// assumes valid/ready records on the encoder clock.
module blfte_host_model
  import blfte_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // record stream
  input wire blfte_record_type rec_in,
  input wire logic rec_valid_in,
  output logic rec_ready_out,
  // bench control and capture
  input wire logic stall_in,
  output blfte_record_type last_out,
  output logic [15:0] count_out
);
  // ----------------------------------------------------------------------
  // consumer
  // ----------------------------------------------------------------------
  // ready moves only just after an edge
  assign rec_ready_out = !stall_in;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_out <= '0;
      count_out <= 16'h0;
    end else if (rec_valid_in && rec_ready_out) begin
      last_out <= rec_in;
      count_out <= count_out + 16'h1;
    end
  end
endmodule

// ---- verification/blfte_encoder_test.sv ----
// blfte_encoder_test: register, frame and event scenarios for the encoder.
// assumes the host model and the bound checker.
module test_blfte_encoder
  import blfte_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // stimulus and plumbing
  // ----------------------------------------------------------------------
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0, avs_write_in = 1'b0, frame_valid_in = 1'b0, bus_error_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out, q;
  logic avs_waitrequest_out, frame_ready_out, rec_valid_out, rec_ready_in, started_out;
  logic trig_in = 1'b0, stall = 1'b0;
  blfte_rx_frame_type frame_in = '0;
  blfte_record_type rec_out, last_rec;
  logic [15:0] rec_cnt, base = 16'h0;
  int error_cnt = 0, checked = 0, cycles = 0;

  blfte_encoder DUT (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_byteenable_in(4'hf), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .frame_valid_in(frame_valid_in), .frame_in(frame_in), .frame_ready_out(frame_ready_out),
    .bus_error_in(bus_error_in), .external_trigger_line_zero_in(trig_in), .rec_out(rec_out),
    .rec_valid_out(rec_valid_out), .rec_ready_in(rec_ready_in), .started_out(started_out));
  blfte_host_model host (.core_clk_in(core_clk_in), .rst_in(rst_in), .rec_in(rec_out),
    .rec_valid_in(rec_valid_out), .rec_ready_out(rec_ready_in), .stall_in(stall),
    .last_out(last_rec), .count_out(rec_cnt));

  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  // hang guard
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] s);
    checked++;
    if (s !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    @(posedge core_clk_in iff !avs_waitrequest_out);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", 40'(e), 40'(q));
  endtask
  task automatic wr(input logic [31:0] d);
    bus(1'b1, REG_CTRL, d);
  endtask
  task automatic send(input blfte_kind_type k, input logic echo, input logic dyn,
                      input logic wake);
    @(posedge core_clk_in);
    frame_in <= '{kind: k, echo: echo, dynamic_segment: dyn, symbol_wakeup: wake,
                  chan_a: 1'b1, cycle_count: 6'h2a, payload_length: 4'h3, identifier: 32'h15,
                  payload: 64'h1122334455667788, default: '0};
    frame_valid_in <= 1'b1;
    @(posedge core_clk_in iff frame_ready_out);
    frame_valid_in <= 1'b0;
  endtask
  // tuple: type, flags, info, length, payload byte zero
  task automatic expect_rec(input logic [39:0] e);
    for (int i = 0; i < 20 && rec_cnt === base; i++) @(posedge core_clk_in);
    base = rec_cnt;
    chk("record", e, {last_rec.frame_type, last_rec.flags, last_rec.info,
        last_rec.payload_length, last_rec.payload[63:56]});
  endtask
  // a record shows at most two cycles after its cause
  task automatic expect_none;
    repeat (3) @(posedge core_clk_in);
    chk("no record", 40'(base), 40'(rec_cnt));
  endtask
  task automatic berr;
    @(posedge core_clk_in);
    bus_error_in <= 1'b1;
    @(posedge core_clk_in);
    bus_error_in <= 1'b0;
  endtask
  task automatic complete_run;
    $display("counts: %0d checks, %0d errors", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(REG_CTRL, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(4'h1, 32'h0);
    $display("test reset done");
    wr(32'h10);
    expect_rec({8'he2, 32'h0});
    send(KIND_DATA, 1'b1, 1'b0, 1'b0);
    expect_rec({8'h00, 8'h80, 8'h00, 8'h03, 8'h11});
    berr();
    expect_rec({8'h02, 32'h0});
    @(posedge core_clk_in);
    trig_in <= 1'b1;
    expect_rec({8'he1, 32'h0});
    trig_in <= 1'b0;
    send(KIND_SYMBOL, 1'b0, 1'b0, 1'b1);
    expect_none();
    rd(REG_DROP_COUNT, 32'h1);
    $display("test can done");
    wr(32'h20);
    wr(32'h1d);
    expect_rec({8'he2, 32'h0});
    send(KIND_DATA, 1'b0, 1'b0, 1'b0);
    expect_rec({8'h20, 8'h10, 8'h2a, 8'h03, 8'h11});
    send(KIND_NULL, 1'b1, 1'b0, 1'b0);
    expect_rec({8'h21, 8'h10, 8'h2a, 8'h00, 8'h00});
    send(KIND_NULL, 1'b0, 1'b1, 1'b0);
    expect_none();
    send(KIND_SYMBOL, 1'b0, 1'b0, 1'b1);
    expect_rec({8'h22, 8'h10, 8'h2a, 8'h03, 8'h01});
    send(KIND_SYMBOL, 1'b0, 1'b0, 1'b0);
    expect_rec({8'h22, 8'h10, 8'h2a, 8'h03, 8'h00});
    wr(32'h09);
    send(KIND_NULL, 1'b0, 1'b0, 1'b0);
    expect_none();
    berr();
    expect_none();
    rd(REG_DROP_COUNT, 32'h2);
    $display("test flexray done");
    wr(32'h20);
    wr(32'h12);
    expect_rec({8'he2, 32'h0});
    @(posedge core_clk_in);
    stall <= 1'b1;
    send(KIND_DATA, 1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge core_clk_in);
    stall <= 1'b0;
    expect_rec({8'h40, 8'h80, 8'h00, 8'h03, 8'h11});
    berr();
    expect_rec({8'h41, 32'h0});
    $display("test lin done");
    complete_run();
  end
endmodule

bind blfte_encoder blfte_encoder_assertions chk_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .frame_valid_in(frame_valid_in), .frame_in(frame_in), .frame_ready_out(frame_ready_out),
  .external_trigger_line_zero_in(external_trigger_line_zero_in), .rec_out(rec_out),
  .rec_valid_out(rec_valid_out), .rec_ready_in(rec_ready_in), .started_out(started_out));
